// ===== design/exvf_pkg.sv
`default_nettype none
package exvf_pkg;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam logic [ADDR_W-1:0] BASE_RESET = 32'h00000000;
	localparam logic [ADDR_W-1:0] RESET_VEC_ADDR = 32'h00000000;
	localparam int VEC_SHIFT = 2;
	localparam logic [ADDR_W-1:0] HALF_STEP = 32'h00000002;
	localparam logic [7:0] VEC_SP = 8'h00;
	localparam logic [7:0] VEC_PC = 8'h01;
	localparam logic [7:0] VEC_SPURIOUS = 8'h18;
	localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
	localparam logic [7:0] VEC_ERR_LO = 8'h02;
	localparam logic [7:0] VEC_ERR_HI = 8'h0F;
	localparam logic [7:0] VEC_RSV1_LO = 8'h10;
	localparam logic [7:0] VEC_RSV1_HI = 8'h17;
	localparam logic [7:0] VEC_TRAP_LO = 8'h20;
	localparam logic [7:0] VEC_TRAP_HI = 8'h2F;
	localparam logic [7:0] VEC_RSV2_LO = 8'h30;
	localparam logic [7:0] VEC_RSV2_HI = 8'h3F;
	localparam logic [7:0] VEC_USER_LO = 8'h40;
	// function codes
	localparam logic [2:0] FC_SUP_DATA = 3'h5;
	localparam logic [2:0] FC_SUP_PROG = 3'h6;
	localparam logic [2:0] FC_CPU_SPACE = 3'h7;
	// vector class codes
	localparam logic [2:0] CLS_RESET = 3'h0;
	localparam logic [2:0] CLS_ERROR = 3'h1;
	localparam logic [2:0] CLS_RESERVED = 3'h2;
	localparam logic [2:0] CLS_SPURIOUS = 3'h3;
	localparam logic [2:0] CLS_AUTOVEC = 3'h4;
	localparam logic [2:0] CLS_TRAP = 3'h5;
	localparam logic [2:0] CLS_USER = 3'h6;

	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
		logic [2:0] fc;
	} exvf_bus_req_s;

	typedef struct packed {
		logic data_size_acknowledge;
		logic bus_error_input;
		logic autovector_request;
		logic [HALF_W-1:0] data;
	} exvf_bus_rsp_s;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_RST_SP_HI = 9'h002,
		ST_RST_SP_LO = 9'h004,
		ST_RST_PC_HI = 9'h008,
		ST_RST_PC_LO = 9'h010,
		ST_IACK = 9'h020,
		ST_VEC_HI = 9'h040,
		ST_VEC_LO = 9'h080,
		ST_HANDLER = 9'h100
	} exvf_state_e;
endpackage
`default_nettype wire

// ===== design/exvf_exception_vector_fetch.sv
// Function
// RULE_01 - vector base clears on reset, relocatable
// RULE_02 - 256 vectors, table spans 1024 bytes
// RULE_03 - vector address is base plus number times four
// RULE_04 - reset loads stack pointer then program counter
// RULE_05 - reset vector fetched from address zero
// RULE_06 - other vectors fetched in supervisor data space
// RULE_07 - interrupter supplies vector or requests autovector
// RULE_08 - autovector number is 24 plus level
// RULE_09 - read 32-bit vector, jump to handler
// RULE_10 - handler runs until return from exception
// RULE_11 - vector numbers grouped into fixed classes
// RULE_12 - base reachable only through control move
// RULE_13 - cycles end by acknowledge or bus error
// RULE_14 - bus error on acknowledge gives spurious vector
`default_nettype none
module exvf_exception_vector_fetch (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic exc_req, // internal exception request pulse
	input wire logic [7:0] exc_vector, // vector number of the exception
	input wire logic irq_req, // interrupt to acknowledge, pulse
	input wire logic [2:0] irq_level, // level being acknowledged
	input wire logic return_from_exception_instr, // handler return pulse
	input wire logic control_register_move_instr, // write to base
	input wire logic [exvf_pkg::ADDR_W-1:0] ctl_wdata, // base write value
	input wire exvf_pkg::exvf_bus_rsp_s bus_rsp_pin, // bus answer pins
	output exvf_pkg::exvf_bus_req_s bus_req, // bus cycle request
	output logic [exvf_pkg::ADDR_W-1:0] vector_base_reg, // base readback
	output logic [exvf_pkg::DATA_W-1:0] stack_pointer_value, // reset stack
	output logic [exvf_pkg::DATA_W-1:0] program_counter_value, // new flow
	output logic pc_load, // program counter loaded, pulse
	output logic in_handler, // handler running
	output logic resume, // return to interrupted program, pulse
	output logic [2:0] vec_class, // class of last vector
	output logic [7:0] last_vector // last vector number used
);
	timeunit 1ns;
	timeprecision 1ns;
	exvf_pkg::exvf_state_e state_q;
	exvf_pkg::exvf_bus_rsp_s rsp_meta_q;
	exvf_pkg::exvf_bus_rsp_s rsp_q;
	logic [7:0] vec_q;
	logic [exvf_pkg::HALF_W-1:0] hi_q;
	logic [exvf_pkg::DATA_W-1:0] saved_pc_q;
	logic term_raw;
	logic term;

	function automatic logic [exvf_pkg::ADDR_W-1:0] vec_addr(
		input logic [exvf_pkg::ADDR_W-1:0] base, input logic [7:0] num);
		vec_addr = base + {22'h000000, num, 2'h0}; // RULE_03 RULE_02
	endfunction

	function automatic logic [2:0] classify(input logic [7:0] n);
		if (n <= exvf_pkg::VEC_PC)
			classify = exvf_pkg::CLS_RESET;
		else if (n <= exvf_pkg::VEC_ERR_HI)
			classify = exvf_pkg::CLS_ERROR;
		else if (n <= exvf_pkg::VEC_RSV1_HI)
			classify = exvf_pkg::CLS_RESERVED;
		else if (n == exvf_pkg::VEC_SPURIOUS)
			classify = exvf_pkg::CLS_SPURIOUS;
		else if (n < exvf_pkg::VEC_TRAP_LO)
			classify = exvf_pkg::CLS_AUTOVEC;
		else if (n <= exvf_pkg::VEC_TRAP_HI)
			classify = exvf_pkg::CLS_TRAP;
		else if (n <= exvf_pkg::VEC_RSV2_HI)
			classify = exvf_pkg::CLS_RESERVED;
		else
			classify = exvf_pkg::CLS_USER; // RULE_11
	endfunction

	// answer pins arrive from outside: two flops
	always_ff @(posedge core_clk)
	begin
		rsp_meta_q <= bus_rsp_pin;
		rsp_q <= rsp_meta_q;
	end

	assign term_raw = rsp_q.data_size_acknowledge | rsp_q.bus_error_input
		| rsp_q.autovector_request; // RULE_13

	// a termination counts only while the request stands: the synchroniser
	// keeps the previous word's answer visible for a few more cycles
	assign term = term_raw & bus_req.req; // RULE_13

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			vector_base_reg <= exvf_pkg::BASE_RESET; // RULE_01
		else if (control_register_move_instr)
			vector_base_reg <= ctl_wdata; // RULE_12
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			state_q <= exvf_pkg::ST_RST_SP_HI; // RULE_04
		else
		begin
			case (state_q)
				exvf_pkg::ST_IDLE, exvf_pkg::ST_HANDLER:
				begin
					if (state_q == exvf_pkg::ST_HANDLER && return_from_exception_instr)
						state_q <= exvf_pkg::ST_IDLE; // RULE_10
					else if (irq_req)
						state_q <= exvf_pkg::ST_IACK;
					else if (exc_req)
						state_q <= exvf_pkg::ST_VEC_HI;
				end
				exvf_pkg::ST_RST_SP_HI:
					if (term) state_q <= exvf_pkg::ST_RST_SP_LO;
				exvf_pkg::ST_RST_SP_LO:
					if (term) state_q <= exvf_pkg::ST_RST_PC_HI;
				exvf_pkg::ST_RST_PC_HI:
					if (term) state_q <= exvf_pkg::ST_RST_PC_LO;
				exvf_pkg::ST_RST_PC_LO:
					if (term) state_q <= exvf_pkg::ST_IDLE;
				exvf_pkg::ST_IACK:
					if (term) state_q <= exvf_pkg::ST_VEC_HI; // RULE_07
				exvf_pkg::ST_VEC_HI:
					if (term) state_q <= exvf_pkg::ST_VEC_LO;
				exvf_pkg::ST_VEC_LO:
					if (term) state_q <= exvf_pkg::ST_HANDLER; // RULE_10
				default:
					state_q <= exvf_pkg::ST_IDLE;
			endcase
		end
	end

	// vector number selection
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			vec_q <= exvf_pkg::VEC_SP;
		else if ((state_q == exvf_pkg::ST_IDLE || state_q == exvf_pkg::ST_HANDLER)
			&& !irq_req && exc_req
			&& !(state_q == exvf_pkg::ST_HANDLER && return_from_exception_instr))
			vec_q <= exc_vector;
		else if (state_q == exvf_pkg::ST_IACK && term)
		begin
			if (rsp_q.bus_error_input)
				vec_q <= exvf_pkg::VEC_SPURIOUS; // RULE_14
			else if (rsp_q.autovector_request)
				vec_q <= exvf_pkg::VEC_AUTO_BASE + {5'h00, irq_level}; // RULE_08
			else
				vec_q <= rsp_q.data[7:0]; // RULE_07
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			bus_req <= '0;
		else
		begin
			bus_req.req <= 1'b0;
			bus_req.addr <= '0;
			bus_req.fc <= exvf_pkg::FC_SUP_DATA;
			case (state_q)
				exvf_pkg::ST_RST_SP_HI, exvf_pkg::ST_RST_SP_LO,
				exvf_pkg::ST_RST_PC_HI, exvf_pkg::ST_RST_PC_LO:
				begin
					bus_req.req <= !term_raw;
					bus_req.fc <= exvf_pkg::FC_SUP_PROG; // RULE_04
					case (state_q)
						exvf_pkg::ST_RST_SP_HI:
							bus_req.addr <= exvf_pkg::RESET_VEC_ADDR; // RULE_05
						exvf_pkg::ST_RST_SP_LO:
							bus_req.addr <= exvf_pkg::RESET_VEC_ADDR + exvf_pkg::HALF_STEP;
						exvf_pkg::ST_RST_PC_HI:
							bus_req.addr <= vec_addr(exvf_pkg::RESET_VEC_ADDR, exvf_pkg::VEC_PC);
						default:
							bus_req.addr <= vec_addr(exvf_pkg::RESET_VEC_ADDR, exvf_pkg::VEC_PC)
								+ exvf_pkg::HALF_STEP;
					endcase
				end
				exvf_pkg::ST_IACK:
				begin
					bus_req.req <= !term_raw;
					bus_req.fc <= exvf_pkg::FC_CPU_SPACE;
					bus_req.addr <= {29'h00000000, irq_level};
				end
				exvf_pkg::ST_VEC_HI:
				begin
					bus_req.req <= !term_raw;
					bus_req.addr <= vec_addr(vector_base_reg, vec_q); // RULE_06
				end
				exvf_pkg::ST_VEC_LO:
				begin
					bus_req.req <= !term_raw;
					bus_req.addr <= vec_addr(vector_base_reg, vec_q) + exvf_pkg::HALF_STEP;
				end
				default:
					bus_req.req <= 1'b0;
			endcase
		end
	end

	// upper halves held, lower halves complete the 32-bit value
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			hi_q <= '0;
		else if (term && (state_q == exvf_pkg::ST_RST_SP_HI
			|| state_q == exvf_pkg::ST_RST_PC_HI || state_q == exvf_pkg::ST_VEC_HI))
			hi_q <= rsp_q.data;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			stack_pointer_value <= '0;
		else if (term && state_q == exvf_pkg::ST_RST_SP_LO)
			stack_pointer_value <= {hi_q, rsp_q.data}; // RULE_04
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			program_counter_value <= '0;
			saved_pc_q <= '0;
			pc_load <= 1'b0;
			resume <= 1'b0;
		end
		else
		begin
			pc_load <= 1'b0;
			resume <= 1'b0;
			if (term && (state_q == exvf_pkg::ST_RST_PC_LO || state_q == exvf_pkg::ST_VEC_LO))
			begin
				program_counter_value <= {hi_q, rsp_q.data}; // RULE_09
				pc_load <= 1'b1;
				if (state_q == exvf_pkg::ST_VEC_LO && !in_handler)
					saved_pc_q <= program_counter_value;
			end
			else if (state_q == exvf_pkg::ST_HANDLER && return_from_exception_instr)
			begin
				program_counter_value <= saved_pc_q; // RULE_10
				pc_load <= 1'b1;
				resume <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			in_handler <= 1'b0;
		else if (state_q == exvf_pkg::ST_VEC_LO && term)
			in_handler <= 1'b1;
		else if (state_q == exvf_pkg::ST_HANDLER && return_from_exception_instr)
			in_handler <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			vec_class <= exvf_pkg::CLS_RESET;
			last_vector <= exvf_pkg::VEC_SP;
		end
		else
		begin
			vec_class <= classify(vec_q); // RULE_11
			last_vector <= vec_q;
		end
	end

	a_base_reset: assert property (@(posedge core_clk)
		sys_rst |=> vector_base_reg == exvf_pkg::BASE_RESET) // RULE_01
		else $error("vector base not cleared by reset");

	a_base_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		!control_register_move_instr |=> $stable(vector_base_reg)) // RULE_12
		else $error("vector base changed without control move");

	a_vec_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == exvf_pkg::ST_VEC_HI && !term_raw |=> bus_req.req
		&& bus_req.addr == vector_base_reg + {22'h000000, vec_q, 2'h0}
		&& bus_req.fc == exvf_pkg::FC_SUP_DATA) // RULE_03 RULE_06
		else $error("vector fetch address or space wrong");

	a_reset_fetch: assert property (@(posedge core_clk)
		sys_rst ##1 !sys_rst |=> bus_req.req && bus_req.addr == exvf_pkg::RESET_VEC_ADDR
		&& bus_req.fc == exvf_pkg::FC_SUP_PROG) // RULE_05 RULE_04
		else $error("reset fetch not at zero in program space");

	a_autovector: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == exvf_pkg::ST_IACK && rsp_q.autovector_request && !rsp_q.bus_error_input
		|=> vec_q == exvf_pkg::VEC_AUTO_BASE + {5'h00, $past(irq_level)}) // RULE_08
		else $error("autovector number wrong");

	a_spurious: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == exvf_pkg::ST_IACK && rsp_q.bus_error_input
		|=> vec_q == exvf_pkg::VEC_SPURIOUS) // RULE_14
		else $error("bus error on acknowledge not spurious");

	a_pc_load: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == exvf_pkg::ST_VEC_LO && term |=> pc_load && in_handler
		&& program_counter_value == {$past(hi_q), $past(rsp_q.data)}) // RULE_09
		else $error("handler address not loaded");

	a_unterminated: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == exvf_pkg::ST_VEC_HI && !term |=> state_q == exvf_pkg::ST_VEC_HI) // RULE_13
		else $error("cycle left without termination");

	a_return: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_q == exvf_pkg::ST_HANDLER && return_from_exception_instr
		|=> resume && !in_handler && state_q == exvf_pkg::ST_IDLE) // RULE_10
		else $error("return from handler not taken");
endmodule
`default_nettype wire

// ===== sim/exvf_peripheral_model.sv
`default_nettype none
module exvf_peripheral_model (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire exvf_pkg::exvf_bus_req_s bus_req, // cycle from the block
	input wire logic [1:0] iack_mode, // 0 vector, 1 autovector, 2 bus error
	input wire logic [7:0] iack_vec, // vector number to supply
	input wire logic [2:0] wait_cyc, // answer delay in cycles
	output exvf_pkg::exvf_bus_rsp_s bus_rsp_pin // answer pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_q;
	function automatic logic [15:0] word_at(input logic [31:0] a);
		return a[15:0] ^ 16'hC35A;
	endfunction
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			bus_rsp_pin <= '0;
			cnt_q <= 3'h0;
		end
		else if (!bus_req.req)
		begin
			// released: terminations off, data lines no longer hold the last word
			bus_rsp_pin.data_size_acknowledge <= 1'b0;
			bus_rsp_pin.bus_error_input <= 1'b0;
			bus_rsp_pin.autovector_request <= 1'b0;
			bus_rsp_pin.data <= ~bus_rsp_pin.data;
			cnt_q <= 3'h0;
		end
		else if (cnt_q != wait_cyc)
			cnt_q <= cnt_q + 3'h1;
		else if (bus_req.fc == exvf_pkg::FC_CPU_SPACE)
		begin
			// acknowledge cycle: supply a vector, ask for autovector, or fail it
			bus_rsp_pin.data_size_acknowledge <= (iack_mode == 2'h0);
			bus_rsp_pin.autovector_request <= (iack_mode == 2'h1);
			bus_rsp_pin.bus_error_input <= (iack_mode == 2'h2);
			bus_rsp_pin.data <= {8'h00, iack_vec};
		end
		else
		begin
			bus_rsp_pin.data_size_acknowledge <= 1'b1;
			bus_rsp_pin.data <= word_at(bus_req.addr);
		end
	end
endmodule
`default_nettype wire

// ===== sim/test_exception_vector_fetch.sv
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
	$display("ERROR %s exp %h got %h", nm, ex, got); end end
module test_exception_vector_fetch;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic exc_req = 1'b0;
	logic irq_req = 1'b0;
	logic ret_pulse = 1'b0;
	logic move_pulse = 1'b0;
	logic [7:0] exc_vector = 8'h00;
	logic [2:0] irq_level = 3'h0;
	logic [31:0] ctl_wdata = 32'h00000000;
	logic [1:0] iack_mode = 2'h0;
	logic [7:0] iack_vec = 8'h00;
	logic [2:0] wait_cyc = 3'h0;
	logic [31:0] base = 32'h00000000;
	logic [31:0] pc0, base_rb, sp, pc;
	logic pc_load, in_handler, resume;
	logic [2:0] vec_class;
	logic [7:0] last_vector;
	exvf_pkg::exvf_bus_req_s bus_req;
	exvf_pkg::exvf_bus_rsp_s rsp;
	int fails = 0;
	int compares = 0;
	always #20 core_clk = ~core_clk;
	exvf_exception_vector_fetch exvf_exception_vector_fetch_i (.core_clk(core_clk),
		.sys_rst(sys_rst), .exc_req(exc_req), .exc_vector(exc_vector), .irq_req(irq_req),
		.irq_level(irq_level), .return_from_exception_instr(ret_pulse),
		.control_register_move_instr(move_pulse), .ctl_wdata(ctl_wdata), .bus_rsp_pin(rsp),
		.bus_req(bus_req), .vector_base_reg(base_rb), .stack_pointer_value(sp),
		.program_counter_value(pc), .pc_load(pc_load), .in_handler(in_handler),
		.resume(resume), .vec_class(vec_class), .last_vector(last_vector));
	exvf_peripheral_model exvf_peripheral_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.bus_req(bus_req), .iack_mode(iack_mode), .iack_vec(iack_vec), .wait_cyc(wait_cyc),
		.bus_rsp_pin(rsp));
	function automatic logic [15:0] word_at(input logic [31:0] a);
		return a[15:0] ^ 16'hC35A;
	endfunction
	task automatic conclude;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic next_req(input bit need_low, output logic [31:0] a, output logic [2:0] f);
		for (int i = 0; i < 300 && need_low && bus_req.req !== 1'b0; i++)
			@(negedge core_clk);
		for (int i = 0; i < 300 && bus_req.req !== 1'b1; i++)
			@(negedge core_clk);
		a = bus_req.addr;
		f = bus_req.fc;
	endtask
	task automatic fetch_return(input bit need_low, input logic [7:0] ev, input logic [2:0] cls);
		logic [31:0] a, ea;
		logic [2:0] f;
		ea = base + {22'h000000, ev, 2'h0};
		next_req(need_low, a, f);
		`CHK("vector address", ea, a)
		`CHK("vector space", exvf_pkg::FC_SUP_DATA, f)
		for (int i = 0; i < 300 && in_handler !== 1'b1; i++)
			@(negedge core_clk);
		`CHK("handler pc", {word_at(ea), word_at(ea + 32'h00000002)}, pc)
		`CHK("vector number", ev, last_vector)
		`CHK("vector class", cls, vec_class)
		ret_pulse = 1'b1;
		@(negedge core_clk);
		ret_pulse = 1'b0;
		`CHK("resume", 1'b1, resume)
		`CHK("resumed pc", pc0, pc)
		`CHK("return pc load", 1'b1, pc_load)
		`CHK("left handler", 1'b0, in_handler)
		repeat (2) @(negedge core_clk);
	endtask
	task automatic t_reset;
		logic [31:0] a;
		logic [2:0] f;
		next_req(1'b0, a, f);
		`CHK("reset fetch address", exvf_pkg::RESET_VEC_ADDR, a)
		`CHK("reset fetch space", exvf_pkg::FC_SUP_PROG, f)
		`CHK("base after reset", exvf_pkg::BASE_RESET, base_rb)
		pc0 = {word_at(32'h00000004), word_at(32'h00000006)};
		for (int i = 0; i < 300 && pc !== pc0; i++)
			@(negedge core_clk);
		`CHK("reset sp", {word_at(32'h00000000), word_at(32'h00000002)}, sp)
		`CHK("reset pc", pc0, pc)
		repeat (4) @(negedge core_clk);
	endtask
	task automatic t_classes;
		logic [7:0] v[7] = '{8'h02, 8'h0F, 8'h10, 8'h20, 8'h30, 8'h40, 8'hFF};
		logic [2:0] c[7] = '{3'h1, 3'h1, 3'h2, 3'h5, 3'h2, 3'h6, 3'h6};
		for (int i = 0; i < 7; i++)
		begin
			wait_cyc = 3'(i);
			exc_vector = v[i];
			exc_req = 1'b1;
			@(negedge core_clk);
			exc_req = 1'b0;
			fetch_return(1'b0, v[i], c[i]);
		end
	endtask
	task automatic t_relocate;
		ctl_wdata = 32'h00012300;
		move_pulse = 1'b1;
		@(negedge core_clk);
		move_pulse = 1'b0;
		base = ctl_wdata;
		`CHK("moved base", base, base_rb)
		exc_vector = 8'h03;
		exc_req = 1'b1;
		@(negedge core_clk);
		exc_req = 1'b0;
		fetch_return(1'b0, 8'h03, exvf_pkg::CLS_ERROR);
	endtask
	task automatic t_iack(input logic [2:0] lvl, input logic [1:0] mode, input logic [7:0] sv,
		input logic [7:0] ev, input logic [2:0] cls);
		logic [31:0] a;
		logic [2:0] f;
		irq_level = lvl;
		iack_mode = mode;
		iack_vec = sv;
		wait_cyc = {1'b0, lvl[1:0]};
		irq_req = 1'b1;
		@(negedge core_clk);
		irq_req = 1'b0;
		next_req(1'b0, a, f);
		`CHK("ack address", {29'h00000000, lvl}, a)
		`CHK("ack space", exvf_pkg::FC_CPU_SPACE, f)
		fetch_return(1'b1, ev, cls);
	endtask
	initial
	begin
		#2000000;
		fails++;
		conclude();
	end
	initial
	begin
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		t_reset();
		t_classes();
		t_relocate();
		for (int l = 1; l < 8; l++)
			t_iack(3'(l), 2'h1, 8'h00, 8'h18 + 8'(l), exvf_pkg::CLS_AUTOVEC);
		t_iack(3'h5, 2'h0, 8'h41, 8'h41, exvf_pkg::CLS_USER);
		t_iack(3'h7, 2'h2, 8'h00, exvf_pkg::VEC_SPURIOUS, exvf_pkg::CLS_SPURIOUS);
		conclude();
	end
endmodule
`default_nettype wire
